// [hdl/vfs_consts.vh]
// constants for the soft-start and fault sequencer
`ifndef VFS_CONSTS_VH
`define VFS_CONSTS_VH

// clock period in nanoseconds (50 MHz)
`define VFS_CLK_NS        20

// overcurrent latch-off delay at 100 percent limit
`define VFS_OC_TIME_NS    50000
`define VFS_OC_CYC        (`VFS_OC_TIME_NS / `VFS_CLK_NS)

// soft-start dac step interval, one code per interval
`define VFS_SS_STEP_NS    500
`define VFS_SS_STEP_CYC   ((`VFS_SS_STEP_NS + `VFS_CLK_NS - 1) / `VFS_CLK_NS)

// least wait after a supply or driver undervoltage before restart
`define VFS_UV_HOLD_NS    10000
`define VFS_UV_HOLD_CYC   ((`VFS_UV_HOLD_NS + `VFS_CLK_NS - 1) / `VFS_CLK_NS)

// overvoltage ramp-down step interval
`define VFS_OV_STEP_NS    500
`define VFS_OV_STEP_CYC   ((`VFS_OV_STEP_NS + `VFS_CLK_NS - 1) / `VFS_CLK_NS)

// timer width, holds every count above
`define VFS_TMR_W         12

// dac width and first code at 0.25 V
`define VFS_DAC_W         8
`define VFS_DAC_ZERO      8'h00
`define VFS_VID_QUARTER   8'h01

// phase output levels
`define VFS_LVL_FLOAT     2'h0
`define VFS_LVL_MID       2'h1
`define VFS_LVL_LOW       2'h2
`define VFS_LVL_HIGH      2'h3

// total current limit scale codes
`define VFS_SCALE_FULL    2'h0
`define VFS_SCALE_THIRD   2'h1
`define VFS_SCALE_HALF    2'h2

// synchronised input bit positions
`define VFS_S_EN          0
`define VFS_S_VCC         1
`define VFS_S_RAMP        2
`define VFS_S_DRV         3
`define VFS_S_CFG         4
`define VFS_S_OC100       5
`define VFS_S_OC150       6
`define VFS_S_UVC         7
`define VFS_S_UVA         8
`define VFS_S_OVD         9
`define VFS_S_OVF         10
`define VFS_S_W           11

`endif

// [hdl/vfs_sequencer.v]
// soft-start, restart and fault latch-off sequencer for a buck controller
`timescale 1ns/100ps
`default_nettype none
`include "vfs_consts.vh"

// What this block does
// - hold regulator off on 5 V or ramp undervoltage
// - ramp supply 4 V lockout only once enabled
// - after driver undervoltage, mid level, restart soft start
// - at enable, phases float during test-current capture
// - after capture, drive phases to mid level
// - then assert driver enable, release error amp
// - counter steps dac to target at fixed rate
// - phase stays mid until its first pulse
// - below 0.25 V use fixed per-phase limit
// - compare limit current at 100 and 150 percent
// - 100 percent for 50 us shuts down
// - 150 percent shuts down at once
// - overcurrent latch cleared only by enable cycle
// - shed phases scale limit to third or half
// - output 300 mV under dac drops power good
// - overvoltage forces low sides high, phases low
// - after overvoltage dac ramps to zero, enable stays
// - overvoltage latch cleared only by enable low
// - soft start and voltage change use 1.75 V
module vfs_sequencer (
	input  wire                  sys_clk,
	input  wire                  nrst,
	input  wire                  enable_in,
	input  wire                  vcc5_ok,
	input  wire                  ramp_supply_sense_ok,
	input  wire                  driver_power_ready,
	input  wire                  config_capture_done,
	input  wire                  current_limit_sense_over_100,
	input  wire                  current_limit_sense_over_150,
	input  wire                  core_uv_trip,
	input  wire                  aux_uv_trip,
	input  wire                  ov_dac_trip,
	input  wire                  ov_fixed_trip,
	input  wire                  dynamic_voltage_change,
	input  wire                  shed_phase_states,
	input  wire                  three_phase_design,
	input  wire [`VFS_DAC_W-1:0] target_code,
	input  wire                  pulse_1,
	input  wire                  pulse_2,
	input  wire                  pulse_aux,
	output reg  [1:0]            phase_1_level,
	output reg  [1:0]            phase_2_level,
	output reg  [1:0]            aux_pulse_output,
	output reg                   low_side_force,
	output reg                   driver_enable_line,
	output reg                   error_amp_release,
	output reg                   test_current_en,
	output reg  [`VFS_DAC_W-1:0] dac_code,
	output reg                   per_phase_limit_sel,
	output reg  [1:0]            limit_scale,
	output reg                   ov_fixed_sel,
	output reg                   core_power_good,
	output reg                   aux_power_good,
	output reg                   ocp_latched,
	output reg                   ovp_latched
);

	// one-hot states
	localparam [7:0] ST_OFF   = 8'h01;
	localparam [7:0] ST_CAPT  = 8'h02;
	localparam [7:0] ST_MID   = 8'h04;
	localparam [7:0] ST_SS    = 8'h08;
	localparam [7:0] ST_RUN   = 8'h10;
	localparam [7:0] ST_UVW   = 8'h20;
	localparam [7:0] ST_OCP   = 8'h40;
	localparam [7:0] ST_OVP   = 8'h80;

	localparam [`VFS_TMR_W-1:0] TMR_ZERO = {`VFS_TMR_W{1'b0}};
	localparam [`VFS_TMR_W-1:0] TMR_ONE  = {{(`VFS_TMR_W-1){1'b0}}, 1'b1};

	// counts as integers, cut to the timer width on purpose
	localparam integer OC_CYC_I = `VFS_OC_CYC;
	localparam integer SS_CYC_I = `VFS_SS_STEP_CYC;
	localparam integer UV_CYC_I = `VFS_UV_HOLD_CYC;
	localparam integer OV_CYC_I = `VFS_OV_STEP_CYC;

	// step reloads one short, as the stepping cycle itself counts
	localparam [`VFS_TMR_W-1:0] OC_CYC   = OC_CYC_I[`VFS_TMR_W-1:0];
	localparam [`VFS_TMR_W-1:0] SS_CYC   = SS_CYC_I[`VFS_TMR_W-1:0] - TMR_ONE;
	localparam [`VFS_TMR_W-1:0] UV_CYC   = UV_CYC_I[`VFS_TMR_W-1:0];
	localparam [`VFS_TMR_W-1:0] OV_CYC   = OV_CYC_I[`VFS_TMR_W-1:0] - TMR_ONE;

	reg                   rst_meta_q;
	reg                   rst_n;
	wire [`VFS_S_W-1:0]   s;
	reg  [7:0]            state_q;
	reg  [7:0]            state_d;
	reg  [`VFS_TMR_W-1:0] tmr_q;
	reg  [`VFS_TMR_W-1:0] tmr_d;
	reg  [`VFS_TMR_W-1:0] oc_cnt_q;
	reg  [`VFS_DAC_W-1:0] dac_d;
	reg  [2:0]            fired_q;
	wire                  en_s;
	wire                  supply_ok;
	wire                  active;
	wire                  ov_trip;
	wire                  oc_expired;

	// reset release through two flops
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// comparator and driver-ready inputs into the clock domain
	vfs_sync #(
		.W (`VFS_S_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({ov_fixed_trip, ov_dac_trip, aux_uv_trip, core_uv_trip,
		            current_limit_sense_over_150, current_limit_sense_over_100, config_capture_done,
		            driver_power_ready, ramp_supply_sense_ok, vcc5_ok,
		            enable_in}),
		.sync_out (s)
	);

	assign en_s = s[`VFS_S_EN];

	// ramp supply is only judged once enabled; off-state ignores it
	assign supply_ok = s[`VFS_S_VCC] & s[`VFS_S_RAMP];

	// states in which the loop regulates
	assign active = (state_q == ST_SS) | (state_q == ST_RUN);

	// fixed threshold in soft start and voltage change, else dac-relative
	assign ov_trip = (state_q == ST_SS | dynamic_voltage_change) ?
	                 s[`VFS_S_OVF] : s[`VFS_S_OVD];

	assign oc_expired = (oc_cnt_q >= OC_CYC - TMR_ONE) & s[`VFS_S_OC100];

	// overcurrent persistence counter, cleared once the fault goes
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_cnt_q <= TMR_ZERO;
		end else if (active & s[`VFS_S_OC100]) begin
			if (!oc_expired)
				oc_cnt_q <= oc_cnt_q + TMR_ONE;
		end else begin
			oc_cnt_q <= TMR_ZERO;
		end
	end

	// sequencing decisions; faults ranked ovp, ocp, then supply
	always @* begin
		state_d = state_q;
		tmr_d   = (tmr_q == TMR_ZERO) ? TMR_ZERO : tmr_q - TMR_ONE;
		dac_d   = dac_code;
		case (state_q)
			ST_OFF: begin
				dac_d = `VFS_DAC_ZERO;
				if (en_s & s[`VFS_S_VCC] & s[`VFS_S_DRV])
					state_d = ST_CAPT;
			end
			ST_CAPT: begin
				if (!en_s)
					state_d = ST_OFF;
				else if (!supply_ok | !s[`VFS_S_DRV]) begin
					state_d = ST_UVW;
					tmr_d   = UV_CYC;
				end else if (s[`VFS_S_CFG])
					state_d = ST_MID;
			end
			ST_MID: begin
				dac_d = `VFS_DAC_ZERO;
				tmr_d = SS_CYC;
				if (!en_s)
					state_d = ST_OFF;
				else if (!supply_ok | !s[`VFS_S_DRV]) begin
					state_d = ST_UVW;
					tmr_d   = UV_CYC;
				end else
					state_d = ST_SS;
			end
			ST_SS, ST_RUN: begin
				if (!en_s)
					state_d = ST_OFF;
				else if (ov_trip) begin
					state_d = ST_OVP;
					tmr_d   = OV_CYC;
				end else if (s[`VFS_S_OC150] | oc_expired)
					state_d = ST_OCP;
				else if (!supply_ok | !s[`VFS_S_DRV]) begin
					state_d = ST_UVW;
					tmr_d   = UV_CYC;
				end else if (state_q == ST_SS) begin
					if (dac_code == target_code)
						state_d = ST_RUN;
					else if (tmr_q == TMR_ZERO) begin
						tmr_d = SS_CYC;
						if (dac_code < target_code)
							dac_d = dac_code + 1'b1;
						else
							dac_d = dac_code - 1'b1;
					end
				end else begin
					dac_d = target_code;
				end
			end
			ST_UVW: begin
				dac_d = `VFS_DAC_ZERO;
				if (!en_s)
					state_d = ST_OFF;
				else if (!supply_ok | !s[`VFS_S_DRV])
					tmr_d = UV_CYC; // hold until every supply is back
				else if (tmr_q == TMR_ZERO)
					state_d = ST_MID;
			end
			ST_OCP: begin
				dac_d = `VFS_DAC_ZERO;
				if (!en_s)
					state_d = ST_OFF;
			end
			ST_OVP: begin
				if (!en_s)
					state_d = ST_OFF;
				else if (dac_code != `VFS_DAC_ZERO & tmr_q == TMR_ZERO) begin
					dac_d = dac_code - 1'b1;
					tmr_d = OV_CYC;
				end
			end
			default: begin
				state_d = ST_OFF;
				dac_d   = `VFS_DAC_ZERO;
			end
		endcase
	end

	// state, timer and dac registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= ST_OFF;
			tmr_q    <= TMR_ZERO;
			dac_code <= `VFS_DAC_ZERO;
		end else begin
			state_q  <= state_d;
			tmr_q    <= tmr_d;
			dac_code <= dac_d;
		end
	end

	// a phase leaves mid only after its first pulse
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fired_q <= 3'h0;
		end else if (!active) begin
			fired_q <= 3'h0;
		end else begin
			fired_q <= fired_q | {pulse_aux, pulse_2, pulse_1};
		end
	end

	// phase level for one output from state, first-pulse flag and pulse
	function [1:0] lvl;
		input [7:0] st;
		input       fired;
		input       pulse;
		begin
			case (st)
				ST_MID, ST_UVW: lvl = `VFS_LVL_MID;
				ST_SS, ST_RUN: begin
					if (!fired & !pulse)
						lvl = `VFS_LVL_MID;
					else if (pulse)
						lvl = `VFS_LVL_HIGH;
					else
						lvl = `VFS_LVL_LOW;
				end
				ST_OVP: lvl = `VFS_LVL_LOW;
				default: lvl = `VFS_LVL_FLOAT;
			endcase
		end
	endfunction

	// registered outputs
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_1_level       <= `VFS_LVL_FLOAT;
			phase_2_level       <= `VFS_LVL_FLOAT;
			aux_pulse_output    <= `VFS_LVL_FLOAT;
			low_side_force      <= 1'b0;
			driver_enable_line  <= 1'b0;
			error_amp_release   <= 1'b0;
			test_current_en     <= 1'b0;
			per_phase_limit_sel <= 1'b1;
			limit_scale         <= `VFS_SCALE_FULL;
			ov_fixed_sel        <= 1'b1;
			core_power_good     <= 1'b0;
			aux_power_good      <= 1'b0;
			ocp_latched         <= 1'b0;
			ovp_latched         <= 1'b0;
		end else begin
			phase_1_level      <= lvl(state_q, fired_q[0], pulse_1);
			phase_2_level      <= lvl(state_q, fired_q[1], pulse_2);
			aux_pulse_output   <= lvl(state_q, fired_q[2], pulse_aux);
			low_side_force     <= (state_q == ST_OVP);
			driver_enable_line <= active | (state_q == ST_OVP);
			error_amp_release  <= active;
			test_current_en    <= (state_q == ST_CAPT);
			per_phase_limit_sel <= (dac_code < `VFS_VID_QUARTER);
			if (!shed_phase_states)
				limit_scale <= `VFS_SCALE_FULL;
			else if (three_phase_design)
				limit_scale <= `VFS_SCALE_THIRD;
			else
				limit_scale <= `VFS_SCALE_HALF;
			ov_fixed_sel    <= (state_q != ST_RUN) | dynamic_voltage_change;
			core_power_good <= (state_q == ST_RUN) & !s[`VFS_S_UVC];
			aux_power_good  <= (state_q == ST_RUN) & !s[`VFS_S_UVA];
			ocp_latched     <= (state_q == ST_OCP);
			ovp_latched     <= (state_q == ST_OVP);
		end
	end

endmodule // vfs_sequencer

`default_nettype wire

// [hdl/vfs_sync.v]
// two-flop synchroniser for a bus of independent levels
`timescale 1ns/100ps
`default_nettype none

module vfs_sync #(
	parameter W = 1
) (
	input  wire         sys_clk,
	input  wire         rst_n,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] meta_q;

	// first stage feeds only the second
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // vfs_sync

`default_nettype wire

// [tb/tb_vfs_sequencer.sv]
// testbench for the soft-start and fault sequencer
`timescale 1ns/100ps
`default_nettype none
`include "vfs_consts.vh"
module tb_vfs_sequencer;
	logic sys_clk, nrst, enable_in, vcc5_ok, ramp_supply_sense_ok, driver_power_ready;
	logic config_capture_done, current_limit_sense_over_100, current_limit_sense_over_150, core_uv_trip, aux_uv_trip;
	logic ov_dac_trip, ov_fixed_trip, dynamic_voltage_change, shed_phase_states;
	logic three_phase_design, pulse_1, pulse_2, pulse_aux, uv_cmd;
	logic low_side_force, driver_enable_line, error_amp_release, test_current_en;
	logic per_phase_limit_sel, ov_fixed_sel, core_power_good, aux_power_good;
	logic ocp_latched, ovp_latched, hs_1, ls_1;
	logic [7:0] target_code, dac_code;
	logic [1:0] phase_1_level, phase_2_level, aux_pulse_output, limit_scale;
	int fail_count, checks;

	vfs_sequencer DUT (.sys_clk, .nrst, .enable_in, .vcc5_ok, .ramp_supply_sense_ok,
		.driver_power_ready, .config_capture_done, .current_limit_sense_over_100, .current_limit_sense_over_150,
		.core_uv_trip, .aux_uv_trip, .ov_dac_trip, .ov_fixed_trip, .dynamic_voltage_change,
		.shed_phase_states, .three_phase_design, .target_code, .pulse_1, .pulse_2,
		.pulse_aux, .phase_1_level, .phase_2_level, .aux_pulse_output, .low_side_force,
		.driver_enable_line, .error_amp_release, .test_current_en, .dac_code,
		.per_phase_limit_sel, .limit_scale, .ov_fixed_sel, .core_power_good,
		.aux_power_good, .ocp_latched, .ovp_latched);
	vfs_gate_driver u_drv (.sys_clk, .nrst, .uv_cmd, .phase_level(phase_1_level),
		.low_side_force, .driver_enable_line, .driver_power_ready,
		.high_side_drive_1(hs_1), .low_side_drive_1(ls_1));

	// clock
	initial begin
		sys_clk = 0;
		forever #10 sys_clk = ~sys_clk;
	end

	task end_of_test;
		if (fail_count == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// bounded wait for the dac to reach a code
	task wait_dac(input logic [7:0] code);
		int i;
		for (i = 0; i < 1000 && dac_code !== code; i++) cyc(1);
		if (i == 1000) begin
			fail_count++;
			$display("wrong value at %0t: dac never reached code", $time);
			end_of_test;
		end
	endtask
	// enable cycle, capture, mid level and soft start
	task bring_up;
		enable_in = 0;
		config_capture_done = 0;
		cyc(8);
		chk(ocp_latched, 0, "overcurrent latch kept");
		chk(ovp_latched, 0, "overvoltage latch kept");
		enable_in = 1;
		cyc(8);
		chk(test_current_en, 1, "no capture");
		chk(phase_1_level, `VFS_LVL_FLOAT, "not floating");
		config_capture_done = 1;
		cyc(8);
		chk(phase_1_level, `VFS_LVL_MID, "not mid");
		chk(driver_enable_line & error_amp_release, 1, "driver not enabled");
		chk(per_phase_limit_sel, 1, "fixed limit off");
		wait_dac(target_code);
		chk(per_phase_limit_sel, 0, "fixed limit kept");
		chk(phase_1_level, `VFS_LVL_MID, "left mid before pulse");
		chk(aux_pulse_output, `VFS_LVL_MID, "aux left mid before pulse");
	endtask
	task t_start;
		bring_up;
		{pulse_1, pulse_aux} = 2'h3;
		cyc(4);
		chk(phase_1_level, `VFS_LVL_HIGH, "pulse high");
		chk(aux_pulse_output, `VFS_LVL_HIGH, "aux pulse high");
		{pulse_1, pulse_aux} = 2'h0;
		cyc(4);
		chk(phase_1_level, `VFS_LVL_LOW, "pulse low");
		chk(aux_pulse_output, `VFS_LVL_LOW, "aux pulse low");
		chk(core_power_good, 1, "power good low");
		chk(aux_power_good, 1, "aux power good low");
		chk(ov_fixed_sel, 0, "fixed ov in run");
		dynamic_voltage_change = 1;
		core_uv_trip = 1;
		aux_uv_trip = 1;
		shed_phase_states = 1;
		three_phase_design = 1;
		cyc(8);
		chk(ov_fixed_sel, 1, "fixed ov off");
		chk(core_power_good, 0, "power good under uv");
		chk(aux_power_good, 0, "aux power good under uv");
		chk(limit_scale, `VFS_SCALE_THIRD, "third");
		three_phase_design = 0;
		dynamic_voltage_change = 0;
		core_uv_trip = 0;
		aux_uv_trip = 0;
		cyc(4);
		chk(limit_scale, `VFS_SCALE_HALF, "half");
		shed_phase_states = 0;
		cyc(4);
		chk(limit_scale, `VFS_SCALE_FULL, "full");
	endtask
	task t_oc100;
		bring_up;
		current_limit_sense_over_100 = 1;
		cyc(2490);
		chk(ocp_latched, 0, "early latch-off");
		cyc(20);
		chk(ocp_latched, 1, "no latch-off");
		current_limit_sense_over_100 = 0;
		cyc(8);
		chk(ocp_latched, 1, "latch cleared");
	endtask
	task t_oc150;
		bring_up;
		current_limit_sense_over_150 = 1;
		cyc(6);
		chk(ocp_latched & ~driver_enable_line, 1, "no fast shutdown");
		current_limit_sense_over_150 = 0;
	endtask
	task t_ov;
		bring_up;
		ov_fixed_trip = 1;
		cyc(8);
		chk(ovp_latched, 0, "fixed ov threshold used in run");
		ov_fixed_trip = 0;
		ov_dac_trip = 1;
		cyc(8);
		chk(low_side_force, 1, "low sides free");
		chk(ls_1, 1, "low side gate not on");
		chk(phase_1_level, `VFS_LVL_LOW, "phase not low");
		ov_dac_trip = 0;
		cyc(150);
		chk(dac_code, 8'h00, "dac not at zero");
		chk(driver_enable_line & ovp_latched, 1, "overvoltage hold");
	endtask
	task t_uv;
		bring_up;
		uv_cmd = 1;
		cyc(1);
		uv_cmd = 0;
		cyc(8);
		chk(phase_1_level, `VFS_LVL_MID, "uv not mid");
		chk(dac_code, 8'h00, "uv dac");
		chk(driver_enable_line, 0, "driver enabled in uv");
		chk({hs_1, ls_1}, 0, "gates not low in uv");
		wait_dac(target_code);
		vcc5_ok = 0;
		cyc(8);
		chk(error_amp_release, 0, "runs on low supply");
		vcc5_ok = 1;
		wait_dac(target_code);
		ramp_supply_sense_ok = 0;
		cyc(8);
		chk(error_amp_release, 0, "runs on low ramp supply");
		ramp_supply_sense_ok = 1;
		wait_dac(target_code);
	endtask

	// reset, then the scenarios
	initial begin
		{nrst, enable_in, config_capture_done, current_limit_sense_over_100, current_limit_sense_over_150} = 0;
		{core_uv_trip, aux_uv_trip, ov_dac_trip, ov_fixed_trip, uv_cmd} = 0;
		{dynamic_voltage_change, shed_phase_states, three_phase_design} = 0;
		{pulse_1, pulse_2, pulse_aux} = 0;
		{vcc5_ok, ramp_supply_sense_ok} = 2'h3;
		target_code = 8'h04;
		fail_count = 0;
		checks = 0;
		cyc(10);
		nrst = 1;
		t_start;
		t_oc100;
		t_oc150;
		t_ov;
		t_uv;
		end_of_test;
	end
endmodule // tb_vfs_sequencer
`default_nettype wire

// [tb/vfs_gate_driver.sv]
// behavioural gate driver on the far side of the phase outputs
`timescale 1ns/100ps
`default_nettype none
module vfs_gate_driver #(
	parameter int HOLD_CYC = 100
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       uv_cmd,
	input  wire logic [1:0] phase_level,
	input  wire logic       low_side_force,
	input  wire logic       driver_enable_line,
	output logic            driver_power_ready,
	output logic            high_side_drive_1,
	output logic            low_side_drive_1
);
	logic [7:0] hold_q;
	// supply loss holds the gates low for a minimum time
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= 8'h00;
		end else if (uv_cmd) begin
			hold_q <= 8'(HOLD_CYC);
		end else if (hold_q != 8'h00) begin
			hold_q <= hold_q - 8'h01;
		end
	end
	// not ready and all gates low while holding
	assign driver_power_ready = (hold_q == 8'h00);
	assign high_side_drive_1 = driver_power_ready && driver_enable_line
		&& phase_level == 2'h3;
	assign low_side_drive_1 = driver_power_ready && driver_enable_line
		&& (low_side_force || phase_level == 2'h2);
endmodule // vfs_gate_driver
`default_nettype wire

// [tb/vfs_seq_asserts.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "vfs_consts.vh"
module vfs_seq_asserts (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       enable_in,
	input wire logic       current_limit_sense_over_150,
	input wire logic       core_uv_trip,
	input wire logic [1:0] phase_1_level,
	input wire logic [1:0] phase_2_level,
	input wire logic       low_side_force,
	input wire logic       driver_enable_line,
	input wire logic       error_amp_release,
	input wire logic       test_current_en,
	input wire logic [7:0] dac_code,
	input wire logic       per_phase_limit_sel,
	input wire logic       core_power_good,
	input wire logic       ocp_latched,
	input wire logic       ovp_latched
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_capt_float: assert property (
		test_current_en |-> phase_1_level == `VFS_LVL_FLOAT && !driver_enable_line)
		else $error("phase driven during capture");
	a_amp_after_drv: assert property (
		error_amp_release |-> driver_enable_line)
		else $error("error amp released without driver enable");
	a_dac_slew_step: assert property (
		!ovp_latched && error_amp_release && $past(error_amp_release)
		&& dac_code != $past(dac_code) |-> dac_code == $past(dac_code) + 8'h01)
		else $error("soft start step not one code");
	a_limit_sel: assert property (
		$stable(dac_code) |-> per_phase_limit_sel == (dac_code < `VFS_VID_QUARTER))
		else $error("limit select wrong for dac code");
	a_oc150_fast: assert property (
		current_limit_sense_over_150 && error_amp_release |-> ##[1:6] ocp_latched)
		else $error("no prompt shutdown at 150 percent");
	a_ocp_holds: assert property (
		ocp_latched && enable_in |=> ocp_latched)
		else $error("overcurrent latch lost with enable high");
	a_ovp_holds: assert property (
		ovp_latched && enable_in |=> ovp_latched)
		else $error("overvoltage latch lost with enable high");
	a_ovp_outputs: assert property (
		ovp_latched && $past(ovp_latched) |-> low_side_force && driver_enable_line
		&& phase_1_level == `VFS_LVL_LOW && phase_2_level == `VFS_LVL_LOW)
		else $error("overvoltage outputs wrong");
	a_ocp_outputs: assert property (
		ocp_latched && $past(ocp_latched) |-> !driver_enable_line && dac_code == 8'h00)
		else $error("overcurrent shutdown outputs wrong");
	a_pg_uv_drop: assert property (
		$rose(core_uv_trip) |-> ##[1:5] !core_power_good)
		else $error("power good kept under undervoltage");
endmodule // vfs_seq_asserts

bind vfs_sequencer vfs_seq_asserts u_chk (.sys_clk, .nrst, .enable_in, .current_limit_sense_over_150,
	.core_uv_trip, .phase_1_level, .phase_2_level, .low_side_force, .driver_enable_line,
	.error_amp_release, .test_current_en, .dac_code, .per_phase_limit_sel,
	.core_power_good, .ocp_latched, .ovp_latched);
`default_nettype wire
